/* testbench.sv */
// self-checking bench for the serial port transmit status and control block
`timescale 1ns/1ps
module testbench;
	localparam int PER = 4;
	logic              core_clk;
	logic              rst_b;
	usc_pkg::usc_req_t req;
	logic [7:0]        rdata;
	logic              tx_out;
	logic              tx_oe;
	logic              rxtx_in;
	logic              rxtx_out;
	logic              rxtx_oe;
	logic              tx_line;
	logic              peer_line;
	logic [3:0]        nbits;
	logic [8:0]        got;
	logic [7:0]        frames;
	logic [7:0]        v;
	logic [7:0]        c1;
	logic [8:0]        w;
	logic [7:0]        f0;
	logic              b9;
	logic              pe;
	int                failures;
	int                tests_run;
	int                k;
	int                n;

	// a released transmit pin is pulled high; a released shared pin carries the peer's line
	assign tx_line = tx_oe ? tx_out : 1'b1;
	assign rxtx_in = rxtx_oe ? rxtx_out : peer_line;

	usc_uart usc_uart_i (.core_clk(core_clk), .rst_b(rst_b), .reg_req(req),
		.reg_rdata(rdata), .tx_out(tx_out), .tx_oe(tx_oe),
		.rxtx_in(rxtx_in), .rxtx_out(rxtx_out), .rxtx_oe(rxtx_oe));
	usc_peer #(.PER(PER)) usc_peer_i (.core_clk(core_clk),
		.tx_line(tx_line), .nbits(nbits), .rx_line(peer_line),
		.got(got), .frames(frames));

	initial core_clk = 1'b0;
	always #20 core_clk = ~core_clk;

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// strobes rise and fall on falling edges, a full cycle apart
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge core_clk);
		req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
		@(negedge core_clk);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge core_clk);
		req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
		@(negedge core_clk);
		req.rd = 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			rd(3'h0, v);
			if (v[1] === 1'b1) return;
		end
		failures++;
		close_out();
	endtask

	task automatic wait_frame();
		for (int i = 0; i < 400; i++) begin
			@(negedge core_clk);
			if (frames !== f0) return;
		end
		failures++;
		close_out();
	endtask

	// frame positions as they should appear on the line, lsb first
	function automatic logic [8:0] frame(input logic [8:0] d,
		input logic b, input logic p, input logic [1:0] t);
		logic [8:0] r;
		logic       q;
		r = b ? d : {1'b0, d[7:0]};
		q = b ? ^d[7:0] : ^d[6:0];
		q = t[1] ? ~t[0] : q ^ t[0];
		if (p) r[b ? 8 : 7] = q;
		return r;
	endfunction

	initial begin
		req = '{addr: 3'h0, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
		rst_b = 1'b0;
		failures = 0;
		tests_run = 0;
		nbits = 4'h8;
		void'($urandom(32'h71D20DA0));
		repeat (8) @(negedge core_clk);
		rst_b = 1'b1;
		rd(3'h0, v);
		check(v, 8'h0B);
		rd(3'h2, v);
		check(v, 8'h00);
		check(tx_oe, 1'b0);
		check(rxtx_oe, 1'b0);
		wr(3'h6, 8'h03);
		wr(3'h5, 8'h00);
		wr(3'h1, 8'h80);
		// armed write with the transmitter off: dropped, flags still cleared
		rd(3'h0, v);
		wr(3'h4, 8'h00);
		rd(3'h0, v);
		check(v[1:0], 2'h0);
		wr(3'h2, 8'hC0);
		rd(3'h0, v);
		check(v[1:0], 2'h3);
		check(tx_oe, 1'b1);
		check(rxtx_oe, 1'b0);
		check(tx_line, 1'b1);
		// second character waits in the hold while the first shifts
		f0 = frames;
		rd(3'h0, v);
		wr(3'h4, 8'hA5);
		rd(3'h0, v);
		wr(3'h4, 8'h3C);
		rd(3'h0, v);
		check(v[1:0], 2'h0);
		wait_frame();
		check(got, 9'h0A5);
		f0 = frames;
		wait_frame();
		check(got, 9'h03C);
		for (k = 0; k < 8; k++) begin
			w = 9'($urandom());
			b9 = 1'($urandom());
			pe = k < 4 ? 1'b1 : 1'($urandom());
			wr(3'h1, {1'b1, b9, pe, k[1:0], 2'h0, w[8]});
			nbits = b9 ? 4'h9 : 4'h8;
			f0 = frames;
			rd(3'h0, v);
			wr(3'h4, w[7:0]);
			rd(3'h0, v);
			check(v[1:0], 2'h1);
			wait_frame();
			check(got, frame(w, b9, pe, k[1:0]));
			wait_idle();
			check(tx_line, 1'b1);
		end
		// break: line held low well past thirteen bit times
		nbits = 4'h8;
		wr(3'h1, 8'h84);
		for (n = 0; n < 100 && tx_line; n++) @(negedge core_clk);
		if (n == 100) begin
			failures++;
			close_out();
		end
		n = 0;
		repeat (13 * PER + 8) begin
			@(negedge core_clk);
			n += int'(tx_line === 1'b0);
		end
		check(9'(n), 9'(13 * PER + 8));
		rd(3'h0, v);
		check(v[1], 1'b0);
		wr(3'h1, 8'h80);
		wait_idle();
		for (k = 0; k < 4; k++) begin
			b9 = k[0];
			pe = k != 3;
			c1 = {1'b1, b9, pe, k[1:0], 3'h0};
			wr(3'h1, c1);
			w = frame(9'($urandom()), b9, pe, k[1:0]);
			if (k == 0) w[7] = ~w[7];
			usc_peer_i.send(w, b9 ? 9 : 8);
			repeat (4) @(negedge core_clk);
			rd(3'h0, v);
			check(v, k == 0 ? 8'h8F : 8'h0F);
			rd(3'h7, v);
			check(v, 8'h01);
			rd(3'h1, v);
			check(v, {c1[7:2], b9 && !pe && w[8], 1'b0});
			rd(3'h4, v);
			check(v, pe && !b9 ? {1'b0, w[6:0]} : w[7:0]);
		end
		// disable in mid-frame with a word still buffered
		c1 = 8'h88;
		wr(3'h1, c1);
		wr(3'h2, 8'hC5);
		usc_peer_i.send(9'h055, 8);
		rd(3'h0, v);
		wr(3'h4, 8'h96);
		repeat (10) @(negedge core_clk);
		wr(3'h1, 8'h08);
		rd(3'h0, v);
		check(v, 8'h0B);
		check(tx_oe, 1'b0);
		check(rxtx_oe, 1'b0);
		rd(3'h7, v);
		check(v, 8'h00);
		rd(3'h2, v);
		check(v, 8'h05);
		rd(3'h1, v);
		check(v & 8'hFC, 8'h08);
		rd(3'h6, v);
		check(v, 8'h03);
		repeat (60) @(negedge core_clk);
		wr(3'h1, c1);
		wr(3'h2, 8'hC5);
		f0 = frames;
		rd(3'h0, v);
		wr(3'h4, 8'h5A);
		wait_frame();
		check(got, frame(9'h05A, 1'b0, 1'b0, 2'h1));
		wait_idle();
		// single-wire pin ownership
		wr(3'h3, 8'h01);
		wr(3'h2, 8'h80);
		repeat (2) @(negedge core_clk);
		check(rxtx_oe, 1'b1);
		check(rxtx_out, 1'b1);
		wr(3'h2, 8'hC0);
		repeat (2) @(negedge core_clk);
		check(rxtx_oe, 1'b0);
		close_out();
	end
endmodule

/* usc_consts.svh */
// constants for the serial port transmit status and control block
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH
// register index on the data memory port
`define USC_A_STAT   3'h0
`define USC_A_CTL1   3'h1
`define USC_A_CTL2   3'h2
`define USC_A_CTL3   3'h3
`define USC_A_DATA   3'h4
`define USC_A_BAUD_DIVISOR_HIGH   3'h5
`define USC_A_BAUD_DIVISOR_LOW   3'h6
`define USC_A_CNT    3'h7
// control one fields
`define USC_C1_UEN   3'h7
`define USC_C1_BNO   3'h6
`define USC_C1_PARITY_ENABLE_BIT  3'h5
`define USC_C1_PRTH  3'h4
`define USC_C1_PRTL  3'h3
`define USC_C1_BRK   3'h2
`define USC_C1_TX8   3'h0
// control two fields
`define USC_C2_TRANSMITTER_ENABLE_BIT  3'h7
`define USC_C2_RECEIVER_ENABLE_BIT  3'h6
`define USC_C2_STOPS 3'h5
// control three field
`define USC_C3_SWM   3'h0
// parity type codes
`define USC_PRT_EVEN 2'h0
`define USC_PRT_ODD  2'h1
`define USC_PRT_MARK 2'h2
`define USC_PRT_SPC  2'h3
// frame lengths in bit positions
`define USC_NBITS8   4'h8
`define USC_NBITS9   4'h9
// final break bit count; the shortest break holds the line low fourteen bit times
`define USC_BRK_BITS 4'hD
// receive fill count saturates at this value
`define USC_CNT_MAX  3'h7
// receive buffer shape
`define USC_FIFO_W   9
`define USC_FIFO_D   16
`define USC_FIFO_AW  4
`endif

/* usc_fifo.sv */
// receive buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
module usc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  logic             core_clk,
	input  logic             rst_b,
	input  logic             flush,
	input  logic             in_valid,
	input  logic [WIDTH-1:0] in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [WIDTH-1:0] out_data,
	input  logic             out_ready,
	output logic [AW:0]      count
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} usc_fifo_st_t;

	usc_fifo_st_t q_ff;
	usc_fifo_st_t nxt_q;
	logic         full;
	logic         empty;

	always_comb begin
		nxt_q = q_ff;
		empty = (q_ff.wp == q_ff.rp);
		full = (q_ff.wp[AW] != q_ff.rp[AW]) &&
			(q_ff.wp[AW-1:0] == q_ff.rp[AW-1:0]);
		in_ready = !full;
		out_valid = !empty;
		out_data = q_ff.mem[q_ff.rp[AW-1:0]];
		count = q_ff.wp - q_ff.rp;
		if (in_valid && !full) begin
			nxt_q.mem[q_ff.wp[AW-1:0]] = in_data;
			nxt_q.wp = q_ff.wp + {{AW{1'b0}}, 1'b1};
		end
		if (out_ready && !empty) begin
			nxt_q.rp = q_ff.rp + {{AW{1'b0}}, 1'b1};
		end
		// flush only moves pointers; stale words stay on out_data while out_valid is low
		if (flush) begin
			nxt_q.wp = '0;
			nxt_q.rp = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule

/* usc_peer.sv */
// remote serial transceiver model facing the transmit and shared pins
`timescale 1ns/1ps
module usc_peer #(
	parameter int PER = 4
) (
	input  wire logic       core_clk,
	input  wire logic       tx_line,
	input  wire logic [3:0] nbits,
	output logic            rx_line,
	output logic [8:0]      got,
	output logic [7:0]      frames
);
	logic [8:0] w;
	initial begin
		rx_line = 1'b1;
		got = 9'h000;
		frames = 8'h00;
	end
	// samples mid-bit, lsb first; a break decodes as a zero frame
	always begin
		@(negedge tx_line);
		w = 9'h000;
		repeat (PER / 2) @(posedge core_clk);
		for (int i = 0; i < nbits; i++) begin
			repeat (PER) @(posedge core_clk);
			w[i] = tx_line;
		end
		repeat (PER) @(posedge core_clk);
		got = w;
		frames = frames + 8'h01;
	end
	// one start, n data positions lsb first, two bit times of stop
	task automatic send(input logic [8:0] v, input int n);
		@(negedge core_clk);
		rx_line = 1'b0;
		repeat (PER) @(negedge core_clk);
		for (int i = 0; i < n; i++) begin
			rx_line = v[i];
			repeat (PER) @(negedge core_clk);
		end
		rx_line = 1'b1;
		repeat (2 * PER) @(negedge core_clk);
	endtask
endmodule

/* usc_pkg.sv */
// types for the serial port transmit status and control block
package usc_pkg;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_STOP  = 5'h08,
		TX_BREAK = 5'h10
	} usc_tx_st_t;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} usc_rx_st_t;
	typedef struct packed {
		logic [2:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} usc_req_t;
	typedef struct packed {
		logic tx_out;
		logic tx_oe;
		logic rxtx_out;
		logic rxtx_oe;
	} usc_pins_t;
	typedef struct packed {
		logic        c1_uen;
		logic        word_length_select;
		logic        parity_enable_bit;
		logic [1:0]  prt;
		logic        brk;
		logic        tx8;
		logic [7:0]  c2;
		logic        single_wire_select;
		logic [7:0]  baud_divisor_high;
		logic [7:0]  baud_divisor_low;
		logic        tx_buffer_empty_flag;
		logic        tx_idle_flag;
		logic        receiver_idle_flag;
		logic        parity_error_flag;
		logic        nf;
		logic        framing_error_flag;
		logic        overrun_flag;
		logic        tx_arm;
		logic        err_arm;
		logic [8:0]  hold;
		logic        hold_vld;
		usc_tx_st_t  tx_st;
		logic [8:0]  tx_sh;
		logic [3:0]  tx_bit;
		logic [15:0] tx_cnt;
		usc_rx_st_t  rx_st;
		logic [8:0]  rx_sh;
		logic [3:0]  rx_bit;
		logic [15:0] rx_cnt;
		logic        rx_prev;
		logic        rx_noise;
		logic [7:0]  rdata;
		logic [2:0]  fill;
		usc_pins_t   pins;
	} usc_state_t;
endpackage

/* usc_uart.sv */
// serial port: transmit status flags, control one, shifters and pins
`timescale 1ns/1ps
`include "usc_consts.svh"
module usc_uart (
	input  logic              core_clk,
	input  logic              rst_b,
	input  usc_pkg::usc_req_t reg_req,
	output logic [7:0]        reg_rdata,
	output logic              tx_out,
	output logic              tx_oe,
	input  logic              rxtx_in,
	output logic              rxtx_out,
	output logic              rxtx_oe
);
	usc_pkg::usc_state_t s_ff;
	usc_pkg::usc_state_t nxt_s;
	logic [15:0]         div;
	logic [3:0]          nbits;
	logic                tx_en;
	logic                rx_en;
	logic                tick_tx;
	logic                tick_rx;
	logic                load;
	logic                rx_evt;
	logic                line;
	logic [8:0]          word;
	logic [8:0]          dlv;
	logic                push_vld;
	logic                push_rdy;
	logic [8:0]          push_word;
	logic                pop_vld;
	logic                pop_rdy;
	logic [8:0]          pop_word;
	logic                fifo_flush;
	logic [4:0]          fifo_cnt;
	logic                data_acc;

	// builds the frame word; also used to check received parity
	function automatic logic [8:0] usc_frame(
		input logic [8:0] d,
		input logic       word_length_select,
		input logic       parity_enable_bit,
		input logic [1:0] prt
	);
		logic [8:0] w;
		logic [7:0] b;
		logic       p;
		w = d;
		b = word_length_select ? d[7:0] : {1'b0, d[6:0]};
		unique case (prt)
			`USC_PRT_EVEN: p = ^b;
			`USC_PRT_ODD:  p = ~^b;
			`USC_PRT_MARK: p = 1'b1;
			`USC_PRT_SPC:  p = 1'b0;
		endcase
		if (!word_length_select) begin
			w[8] = 1'b0;
		end
		if (parity_enable_bit) begin
			if (word_length_select) begin
				w[8] = p;
			end else begin
				w[7] = p;
			end
		end
		return w;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		push_vld = 1'b0;
		push_word = '0;
		pop_rdy = 1'b0;
		fifo_flush = 1'b0;
		load = 1'b0;
		rx_evt = 1'b0;
		div = {s_ff.baud_divisor_high, s_ff.baud_divisor_low};
		nbits = s_ff.word_length_select ? `USC_NBITS9 : `USC_NBITS8;
		tx_en = s_ff.c1_uen & s_ff.c2[`USC_C2_TRANSMITTER_ENABLE_BIT];
		rx_en = s_ff.c1_uen & s_ff.c2[`USC_C2_RECEIVER_ENABLE_BIT];
		tick_tx = (s_ff.tx_cnt == '0);
		tick_rx = (s_ff.rx_cnt == '0);
		word = s_ff.word_length_select ? s_ff.rx_sh : {1'b0, s_ff.rx_sh[8:1]};
		dlv = word;
		if (s_ff.parity_enable_bit) begin
			if (s_ff.word_length_select) begin
				dlv[8] = 1'b0;
			end else begin
				dlv[7] = 1'b0;
			end
		end
		data_acc = (reg_req.rd | reg_req.wr) &&
			(reg_req.addr == `USC_A_DATA);

		// transmitter
		nxt_s.tx_cnt = tick_tx ? div : s_ff.tx_cnt - 16'h0001;
		unique case (s_ff.tx_st)
			usc_pkg::TX_IDLE: begin
				if (tx_en & s_ff.hold_vld) begin
					load = 1'b1;
					nxt_s.hold_vld = 1'b0;
					nxt_s.tx_sh = usc_frame(s_ff.hold, s_ff.word_length_select,
						s_ff.parity_enable_bit, s_ff.prt);
					nxt_s.tx_st = usc_pkg::TX_START;
					nxt_s.tx_cnt = div;
				end else if (tx_en & s_ff.brk) begin
					// break waits behind any held character
					nxt_s.tx_st = usc_pkg::TX_BREAK;
					nxt_s.tx_cnt = div;
					nxt_s.tx_bit = '0;
				end
			end
			usc_pkg::TX_START: begin
				if (tick_tx) begin
					nxt_s.tx_st = usc_pkg::TX_DATA;
					nxt_s.tx_bit = '0;
				end
			end
			usc_pkg::TX_DATA: begin
				if (tick_tx) begin
					nxt_s.tx_sh = {1'b0, s_ff.tx_sh[8:1]};
					nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
					if (s_ff.tx_bit == nbits - 4'h1) begin
						nxt_s.tx_st = usc_pkg::TX_STOP;
						nxt_s.tx_bit = '0;
					end
				end
			end
			usc_pkg::TX_STOP: begin
				if (tick_tx) begin
					nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
					if (s_ff.tx_bit ==
						{3'h0, s_ff.c2[`USC_C2_STOPS]}) begin
						nxt_s.tx_st = usc_pkg::TX_IDLE;
					end
				end
			end
			usc_pkg::TX_BREAK: begin
				if (tick_tx) begin
					if (s_ff.tx_bit != `USC_BRK_BITS) begin
						nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
					end else if (!s_ff.brk) begin
						nxt_s.tx_st = usc_pkg::TX_IDLE;
					end
				end
			end
			default: nxt_s.tx_st = usc_pkg::TX_IDLE;
		endcase

		// receiver: start sampled at half a bit, then once per bit
		nxt_s.rx_cnt = tick_rx ? div : s_ff.rx_cnt - 16'h0001;
		nxt_s.rx_prev = rxtx_in;
		unique case (s_ff.rx_st)
			usc_pkg::RX_IDLE: begin
				if (rx_en & !rxtx_in) begin
					nxt_s.rx_st = usc_pkg::RX_START;
					nxt_s.rx_cnt = {1'b0, div[15:1]};
					nxt_s.rx_noise = 1'b0;
				end
			end
			usc_pkg::RX_START: begin
				if (tick_rx) begin
					nxt_s.rx_st = rxtx_in ? usc_pkg::RX_IDLE :
						usc_pkg::RX_DATA;
					nxt_s.rx_bit = '0;
				end
			end
			usc_pkg::RX_DATA: begin
				if (tick_rx) begin
					nxt_s.rx_sh = {rxtx_in, s_ff.rx_sh[8:1]};
					nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
					// a change right at the sample point counts as noise
					if (rxtx_in != s_ff.rx_prev) begin
						nxt_s.rx_noise = 1'b1;
					end
					if (s_ff.rx_bit == nbits - 4'h1) begin
						nxt_s.rx_st = usc_pkg::RX_STOP;
					end
				end
			end
			usc_pkg::RX_STOP: begin
				if (tick_rx) begin
					rx_evt = 1'b1;
					nxt_s.rx_st = usc_pkg::RX_IDLE;
				end
			end
			default: nxt_s.rx_st = usc_pkg::RX_IDLE;
		endcase

		// register port
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`USC_A_STAT: begin
					nxt_s.rdata = {s_ff.parity_error_flag, s_ff.nf, s_ff.framing_error_flag,
						s_ff.overrun_flag, s_ff.receiver_idle_flag, pop_vld, s_ff.tx_idle_flag,
						s_ff.tx_buffer_empty_flag};
					nxt_s.tx_arm = s_ff.tx_buffer_empty_flag | s_ff.tx_idle_flag;
					nxt_s.err_arm = 1'b1;
				end
				`USC_A_CTL1: nxt_s.rdata = {s_ff.c1_uen, s_ff.word_length_select,
					s_ff.parity_enable_bit, s_ff.prt, s_ff.brk, pop_word[8], 1'b0};
				`USC_A_CTL2: nxt_s.rdata = s_ff.c2;
				`USC_A_CTL3: nxt_s.rdata = {7'h00, s_ff.single_wire_select};
				`USC_A_DATA: begin
					nxt_s.rdata = pop_word[7:0];
					pop_rdy = pop_vld;
				end
				`USC_A_BAUD_DIVISOR_HIGH: nxt_s.rdata = s_ff.baud_divisor_high;
				`USC_A_BAUD_DIVISOR_LOW: nxt_s.rdata = s_ff.baud_divisor_low;
				`USC_A_CNT:  nxt_s.rdata = {5'h00, s_ff.fill};
			endcase
		end else if (reg_req.wr) begin
			unique case (reg_req.addr)
				`USC_A_STAT, `USC_A_CNT: begin
				end
				`USC_A_CTL1: begin
					nxt_s.c1_uen = reg_req.wdata[`USC_C1_UEN];
					nxt_s.word_length_select = reg_req.wdata[`USC_C1_BNO];
					nxt_s.parity_enable_bit = reg_req.wdata[`USC_C1_PARITY_ENABLE_BIT];
					nxt_s.prt = reg_req.wdata[`USC_C1_PRTH:`USC_C1_PRTL];
					nxt_s.brk = reg_req.wdata[`USC_C1_BRK];
					nxt_s.tx8 = reg_req.wdata[`USC_C1_TX8];
				end
				`USC_A_CTL2: begin
					if (reg_req.wdata[`USC_C2_TRANSMITTER_ENABLE_BIT] &
						!s_ff.c2[`USC_C2_TRANSMITTER_ENABLE_BIT]) begin
						nxt_s.tx_buffer_empty_flag = 1'b1;
					end
					nxt_s.c2 = reg_req.wdata;
				end
				`USC_A_CTL3: nxt_s.single_wire_select = reg_req.wdata[`USC_C3_SWM];
				`USC_A_DATA: begin
					nxt_s.hold = {s_ff.tx8, reg_req.wdata};
					nxt_s.hold_vld = 1'b1;
					if (s_ff.tx_arm) begin
						nxt_s.tx_buffer_empty_flag = 1'b0;
						nxt_s.tx_idle_flag = 1'b0;
						nxt_s.tx_arm = 1'b0;
					end
				end
				`USC_A_BAUD_DIVISOR_HIGH: nxt_s.baud_divisor_high = reg_req.wdata;
				`USC_A_BAUD_DIVISOR_LOW: nxt_s.baud_divisor_low = reg_req.wdata;
			endcase
		end
		if (data_acc && s_ff.err_arm) begin
			nxt_s.parity_error_flag = 1'b0;
			nxt_s.nf = 1'b0;
			nxt_s.framing_error_flag = 1'b0;
			nxt_s.overrun_flag = 1'b0;
			nxt_s.err_arm = 1'b0;
		end

		// hardware sets come after software clears so they win
		if (load) begin
			nxt_s.tx_buffer_empty_flag = 1'b1;
		end
		if (rx_evt) begin
			if (push_rdy) begin
				push_vld = 1'b1;
				push_word = dlv;
				nxt_s.framing_error_flag = nxt_s.framing_error_flag | !rxtx_in;
				nxt_s.nf = nxt_s.nf | s_ff.rx_noise;
				nxt_s.parity_error_flag = nxt_s.parity_error_flag | (s_ff.parity_enable_bit &
					(usc_frame(word, s_ff.word_length_select, s_ff.parity_enable_bit,
					s_ff.prt) != word));
			end else begin
				nxt_s.overrun_flag = 1'b1;
			end
		end

		// dropping an enable aborts that direction; a dropped transmit enable also empties the hold
		if (!(nxt_s.c1_uen & nxt_s.c2[`USC_C2_TRANSMITTER_ENABLE_BIT])) begin
			nxt_s.tx_st = usc_pkg::TX_IDLE;
			nxt_s.hold_vld = 1'b0;
		end
		if (!(nxt_s.c1_uen & nxt_s.c2[`USC_C2_RECEIVER_ENABLE_BIT])) begin
			nxt_s.rx_st = usc_pkg::RX_IDLE;
		end

		if (nxt_s.hold_vld | nxt_s.brk |
			(nxt_s.tx_st != usc_pkg::TX_IDLE)) begin
			nxt_s.tx_idle_flag = 1'b0;
		end else if (nxt_s.tx_buffer_empty_flag) begin
			nxt_s.tx_idle_flag = 1'b1;
		end
		nxt_s.receiver_idle_flag = (nxt_s.rx_st == usc_pkg::RX_IDLE);

		// unit off: word length, parity, divisor and swm are untouched
		if (!nxt_s.c1_uen) begin
			nxt_s.c2[`USC_C2_TRANSMITTER_ENABLE_BIT] = 1'b0;
			nxt_s.c2[`USC_C2_RECEIVER_ENABLE_BIT] = 1'b0;
			nxt_s.brk = 1'b0;
			nxt_s.parity_error_flag = 1'b0;
			nxt_s.nf = 1'b0;
			nxt_s.framing_error_flag = 1'b0;
			nxt_s.overrun_flag = 1'b0;
			nxt_s.tx_buffer_empty_flag = 1'b1;
			nxt_s.tx_idle_flag = 1'b1;
			nxt_s.receiver_idle_flag = 1'b1;
			nxt_s.tx_arm = 1'b0;
			nxt_s.err_arm = 1'b0;
			nxt_s.tx_st = usc_pkg::TX_IDLE;
			nxt_s.rx_st = usc_pkg::RX_IDLE;
			nxt_s.tx_cnt = '0;
			nxt_s.rx_cnt = '0;
			push_vld = 1'b0;
			fifo_flush = 1'b1;
		end
		if (fifo_flush) begin
			nxt_s.fill = '0;
		end else if (fifo_cnt > {2'h0, `USC_CNT_MAX}) begin
			nxt_s.fill = `USC_CNT_MAX;
		end else begin
			nxt_s.fill = fifo_cnt[2:0];
		end

		// pins, registered from the next state
		unique case (nxt_s.tx_st)
			usc_pkg::TX_DATA: line = nxt_s.tx_sh[0];
			usc_pkg::TX_START, usc_pkg::TX_BREAK: line = 1'b0;
			default: line = 1'b1;
		endcase
		nxt_s.pins.tx_out = line;
		nxt_s.pins.rxtx_out = line;
		nxt_s.pins.tx_oe = nxt_s.c1_uen &
			nxt_s.c2[`USC_C2_TRANSMITTER_ENABLE_BIT];
		// receive enable wins the shared pin in single-wire mode
		nxt_s.pins.rxtx_oe = nxt_s.c1_uen & nxt_s.single_wire_select &
			nxt_s.c2[`USC_C2_TRANSMITTER_ENABLE_BIT] & !nxt_s.c2[`USC_C2_RECEIVER_ENABLE_BIT];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_ff <= '0;
			s_ff.tx_buffer_empty_flag <= 1'b1;
			s_ff.tx_idle_flag <= 1'b1;
			s_ff.receiver_idle_flag <= 1'b1;
			s_ff.tx_st <= usc_pkg::TX_IDLE;
			s_ff.rx_st <= usc_pkg::RX_IDLE;
			s_ff.pins.tx_out <= 1'b1;
			s_ff.pins.rxtx_out <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	usc_fifo #(
		.WIDTH (`USC_FIFO_W),
		.DEPTH (`USC_FIFO_D),
		.AW    (`USC_FIFO_AW)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.flush     (fifo_flush),
		.in_valid  (push_vld),
		.in_data   (push_word),
		.in_ready  (push_rdy),
		.out_valid (pop_vld),
		.out_data  (pop_word),
		.out_ready (pop_rdy),
		.count     (fifo_cnt)
	);

	assign reg_rdata = s_ff.rdata;
	assign tx_out = s_ff.pins.tx_out;
	assign tx_oe = s_ff.pins.tx_oe;
	assign rxtx_out = s_ff.pins.rxtx_out;
	assign rxtx_oe = s_ff.pins.rxtx_oe;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_idle_needs_empty: assert property (
		s_ff.tx_idle_flag |-> s_ff.tx_buffer_empty_flag && s_ff.tx_st == usc_pkg::TX_IDLE)
		else $error("idle flag set without empty idle transmitter");
	a_idle_line_high: assert property (
		s_ff.tx_idle_flag && s_ff.pins.tx_oe |-> s_ff.pins.tx_out)
		else $error("line not high while idle");
	a_idle_clear_seq: assert property (
		$fell(s_ff.tx_idle_flag) |-> $past(data_acc && reg_req.wr) ||
		s_ff.hold_vld || s_ff.brk || s_ff.tx_st != usc_pkg::TX_IDLE)
		else $error("idle flag cleared without cause");
	a_no_idle_queued: assert property (
		s_ff.hold_vld || s_ff.brk |-> !s_ff.tx_idle_flag)
		else $error("idle flag set with work queued");
	a_load_sets_empty: assert property (
		s_ff.tx_st == usc_pkg::TX_IDLE && s_ff.hold_vld && tx_en &&
		!reg_req.wr |=> s_ff.tx_buffer_empty_flag && s_ff.tx_st == usc_pkg::TX_START)
		else $error("load did not set buffer empty");
	a_transmitter_enable_bit_sets_empty: assert property (
		reg_req.wr && !reg_req.rd && reg_req.addr == `USC_A_CTL2 &&
		reg_req.wdata[`USC_C2_TRANSMITTER_ENABLE_BIT] |=> s_ff.tx_buffer_empty_flag)
		else $error("transmitter enable missed buffer empty");
	a_off_floats: assert property (
		!s_ff.c1_uen |-> !s_ff.pins.tx_oe && !s_ff.pins.rxtx_oe)
		else $error("pin driven while unit off");
	a_off_resets: assert property (
		$fell(s_ff.c1_uen) |-> s_ff.tx_buffer_empty_flag && s_ff.tx_idle_flag &&
		s_ff.receiver_idle_flag && s_ff.c2[7:6] == 2'h0 && !s_ff.brk &&
		!s_ff.overrun_flag && s_ff.fill == '0 ##1 !pop_vld)
		else $error("disable did not reset state");
	a_tx_drive: assert property (
		s_ff.pins.tx_oe |-> s_ff.c1_uen && s_ff.c2[`USC_C2_TRANSMITTER_ENABLE_BIT])
		else $error("transmit pin driven while disabled");
	a_break_len: assert property (
		$past(s_ff.tx_st) == usc_pkg::TX_BREAK &&
		s_ff.tx_st == usc_pkg::TX_IDLE && tx_en |->
		$past(s_ff.tx_bit) == `USC_BRK_BITS && !$past(s_ff.brk))
		else $error("break ended early");
	a_break_low: assert property (
		s_ff.tx_st == usc_pkg::TX_BREAK |-> !s_ff.pins.tx_out)
		else $error("line high during break");

	c_frame_done: cover property (
		s_ff.tx_st == usc_pkg::TX_STOP ##1 s_ff.tx_st == usc_pkg::TX_IDLE);
	c_rx_push: cover property (push_vld && push_rdy);
	c_rx_overrun: cover property (rx_evt && !push_rdy);
	c_break_run: cover property (s_ff.tx_st == usc_pkg::TX_BREAK);
endmodule
